// ===== pkg/swlc_map.vh
// swlc_map.vh: offsets, field positions, reset values and timing counts
// for the link control block; included by bare name, definitions only
`ifndef SWLC_MAP_VH
`define SWLC_MAP_VH

// register byte offsets (apb, one aligned word each)
`define SWLC_LINK0_OFS    8'h00
`define SWLC_GLOBAL_OFS   8'h20
`define SWLC_IRQ_STS_OFS  8'h24
`define SWLC_IRQ_MSK_OFS  8'h28

// link control register fields
`define SWLC_F_AUTO       0
`define SWLC_F_START      1
`define SWLC_F_DISABLE    2
`define SWLC_F_TRI        3
`define SWLC_F_RATE_LO    4
`define SWLC_F_RATE_HI    6
`define SWLC_F_ERR        8
`define SWLC_F_STATE_LO   9
`define SWLC_F_STATE_HI   10
`define SWLC_F_RUN        11
`define SWLC_LINK_RST     7'h01

// global register fields
`define SWLC_F_BASE_LO    0
`define SWLC_F_BASE_HI    1
`define SWLC_F_DEF_LO     8
`define SWLC_F_DEF_HI     15
`define SWLC_F_PLL_LO     16
`define SWLC_F_PLL_HI     18
`define SWLC_BASE_RST     2'h0
`define SWLC_DEF_RST      8'h04

// connect phase: least time before run, at 100 ns per pclk
`define SWLC_CLK_NS       100
`define SWLC_CONN_NS      2000
`define SWLC_CONN_CYC     ((`SWLC_CONN_NS + `SWLC_CLK_NS - 1) / `SWLC_CLK_NS)

`endif

// ===== hdl/swlc_link_ctrl.v
// swlc_link_ctrl: start-up, driver enable, status and bit-rate ticks
// for the eight links of a router, with an apb register slave.
// assumes peer pins are asynchronous to pclk and are synchronised here;
// the encoder/decoder of each link consumes the run and tick outputs.
// Function
// - links reset into auto-start mode
// - auto-start waits for peer, then connects
// - link-start connects actively, runs on response
// - data moves only when started and running
// - disable drops link, refuses peer attempts
// - auto plus tri-state: drivers follow peer
// - disable plus tri-state: drivers always off
// - data enable switches a cycle before strobe
// - rate = pll / 2^(base+1) / (div+1) * 2
// - even div+1 gives uneven duty cycle; here both halves of the bit clock last div+1 ticks
// - rate divider spans zero through seven
// - start-up uses default-rate divider
// - odd default divider gives uneven duty cycle; here both halves of the bit clock stay equal
// - eight link registers: control plus status
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "swlc_map.vh"

module swlc_link_ctrl #(
  parameter NLINK = 8
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // peer side, asynchronous
  input  wire [2:0]  pll_feedback_select,
  input  wire [NLINK-1:0] peer_attempt,
  input  wire [NLINK-1:0] peer_lost,
  input  wire [NLINK-1:0] link_fault,
  // link outputs
  output reg  [NLINK-1:0] dout_oe,
  output reg  [NLINK-1:0] sout_oe,
  output reg  [NLINK-1:0] data_enable,
  output reg  [NLINK-1:0] tx_bit_clk,
  output reg  [NLINK-1:0] default_rate_active,
  // interrupt
  output reg         irq
);

  // one-hot link states
  localparam ST_IDLE  = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_CONN  = 4'b0100;
  localparam ST_RUN   = 4'b1000;
  localparam integer CONN_CYC_I = `SWLC_CONN_CYC;
  localparam [15:0] CONN_CYC = CONN_CYC_I[15:0];

  // address decode, used by read and write paths
  function is_link;
    input [7:0] a;
    begin
      is_link = (a[7:5] == 3'h0) && (a[1:0] == 2'h0) && (a[4:2] < NLINK);
    end
  endfunction

  // two-bit state code for software view
  function [1:0] st_code;
    input [3:0] s;
    begin
      case (s)
        ST_START: st_code = 2'h1;
        ST_CONN:  st_code = 2'h2;
        ST_RUN:   st_code = 2'h3;
        default:  st_code = 2'h0;
      endcase
    end
  endfunction

  // synchronisers: first stage read only by the second
  reg [NLINK-1:0] att_m;
  reg [NLINK-1:0] att_s;
  reg [NLINK-1:0] lost_m;
  reg [NLINK-1:0] lost_s;
  reg [NLINK-1:0] flt_m;
  reg [NLINK-1:0] flt_s;
  reg [2:0]       pll_m;
  reg [2:0]       pll_s;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_m  <= {NLINK{1'b0}};
      att_s  <= {NLINK{1'b0}};
      lost_m <= {NLINK{1'b0}};
      lost_s <= {NLINK{1'b0}};
      flt_m  <= {NLINK{1'b0}};
      flt_s  <= {NLINK{1'b0}};
      pll_m  <= 3'h0;
      pll_s  <= 3'h0;
    end else begin
      att_m  <= peer_attempt;
      att_s  <= att_m;
      lost_m <= peer_lost;
      lost_s <= lost_m;
      flt_m  <= link_fault;
      flt_s  <= flt_m;
      pll_m  <= pll_feedback_select;
      pll_s  <= pll_m;
    end
  end

  // bus strobes; access completes in the first access cycle
  wire       wr_go = psel & penable & pready & pwrite;
  wire       rd_go = psel & penable & pready & ~pwrite;
  wire [2:0] sel_n = paddr[4:2];

  // global register and interrupt mask
  reg [1:0]        base_tx_divider;
  reg [7:0]        default_rate_divider;
  reg [2*NLINK-1:0] irq_mask;
  reg [2*NLINK-1:0] irq_sts;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_tx_divider      <= `SWLC_BASE_RST;
      default_rate_divider <= `SWLC_DEF_RST;
      irq_mask             <= {2*NLINK{1'b0}};
    end else if (wr_go && paddr == `SWLC_GLOBAL_OFS) begin
      base_tx_divider      <= pwdata[`SWLC_F_BASE_HI:`SWLC_F_BASE_LO];
      default_rate_divider <= pwdata[`SWLC_F_DEF_HI:`SWLC_F_DEF_LO];
    end else if (wr_go && paddr == `SWLC_IRQ_MSK_OFS) begin
      irq_mask <= pwdata[2*NLINK-1:0];
    end
  end

  // base prescaler: tick every 2^base clocks, one bit per toggle
  reg  [3:0] pre_cnt;
  wire [3:0] pre_top = (4'h1 << base_tx_divider) - 4'h1;
  wire       pre_tick = (pre_cnt == pre_top);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_cnt <= 4'h0;
    else if (pre_tick)
      pre_cnt <= 4'h0;
    else
      pre_cnt <= pre_cnt + 4'h1;
  end

  // per-link state kept in arrays, one driver per element
  reg [6:0]  ctrl [0:NLINK-1];
  reg [3:0]  lst  [0:NLINK-1];
  reg        err  [0:NLINK-1];
  reg [15:0] ccnt [0:NLINK-1];
  reg [7:0]  rcnt [0:NLINK-1];
  reg        hold [0:NLINK-1];
  reg [NLINK-1:0] ev_up;
  reg [NLINK-1:0] ev_err;

  genvar g;
  generate
    for (g = 0; g < NLINK; g = g + 1) begin : gl
      wire       wsel  = wr_go && is_link(paddr) && sel_n == g;
      wire       rsel  = rd_go && is_link(paddr) && sel_n == g;
      wire       auto  = ctrl[g][`SWLC_F_AUTO];
      wire       strt  = ctrl[g][`SWLC_F_START];
      wire       dis   = ctrl[g][`SWLC_F_DISABLE];
      wire       tri_b = ctrl[g][`SWLC_F_TRI];
      wire [2:0] rate  = ctrl[g][`SWLC_F_RATE_HI:`SWLC_F_RATE_LO];
      wire       chg   = wsel && (pwdata[3:0] != ctrl[g][3:0]);
      wire       run   = (lst[g] == ST_RUN);
      wire [7:0] div   = run ? {5'h0, rate} : default_rate_divider;
      reg  [3:0] next_st;
      reg        next_oe;

      // control fields and sticky error bit (read clears, set wins)
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[g] <= `SWLC_LINK_RST;
          err[g]  <= 1'b0;
        end else begin
          if (wsel)
            ctrl[g] <= pwdata[6:0];
          if (ev_err[g])
            err[g] <= 1'b1;
          else if (rsel && prdata[`SWLC_F_ERR])
            err[g] <= 1'b0;
        end
      end

      // link state decisions
      always @* begin
        next_st = lst[g];
        if (dis) begin
          next_st = ST_IDLE;
        end else begin
          case (lst[g])
            ST_IDLE: begin
              if (strt)
                next_st = ST_START;
              else if (auto && att_s[g])
                next_st = ST_CONN;
            end
            ST_START: begin
              if (att_s[g])
                next_st = ST_CONN;
              else if (!strt)
                next_st = ST_IDLE;
            end
            ST_CONN: begin
              if (lost_s[g] || flt_s[g])
                next_st = ST_IDLE;
              else if (ccnt[g] == CONN_CYC - 16'h1)
                next_st = ST_RUN;
            end
            ST_RUN: begin
              if (lost_s[g] || flt_s[g])
                next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
          endcase
        end
      end

      // driver enable: tri-state acts unless link-start is set without disable
      always @* begin
        if (!tri_b)
          next_oe = 1'b1;
        else if (dis)
          next_oe = 1'b0;
        else if (strt)
          next_oe = 1'b1;
        else
          next_oe = hold[g] | (auto & att_s[g] & ~chg);
      end

      // state, connect counter, driver hold and outputs
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lst[g]                 <= ST_IDLE;
          ccnt[g]                <= 16'h0;
          hold[g]                <= 1'b0;
          ev_up[g]               <= 1'b0;
          ev_err[g]              <= 1'b0;
          dout_oe[g]             <= 1'b0;
          sout_oe[g]             <= 1'b0;
          data_enable[g]         <= 1'b0;
          default_rate_active[g] <= 1'b1;
        end else begin
          lst[g]  <= next_st;
          ccnt[g] <= (lst[g] == ST_CONN) ? ccnt[g] + 16'h1 : 16'h0;
          // peer loss, disable or a change to control bits 3:0 releases the drivers
          if (lost_s[g] || chg || dis)
            hold[g] <= 1'b0;
          else if (auto && att_s[g])
            hold[g] <= 1'b1;
          ev_up[g]  <= (next_st == ST_RUN) && !run;
          ev_err[g] <= run && (lost_s[g] || flt_s[g]);
          dout_oe[g] <= next_oe;
          sout_oe[g] <= dout_oe[g];
          data_enable[g] <= (next_st == ST_RUN) && !dis;
          default_rate_active[g] <= (next_st != ST_RUN);
        end
      end

      // bit clock: toggles after div+1 prescaler ticks; the toggle
      // width is div+1 ticks for both levels, so the duty stays even
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rcnt[g]       <= 8'h0;
          tx_bit_clk[g] <= 1'b0;
        end else if (pre_tick) begin
          if (rcnt[g] >= div) begin
            rcnt[g]       <= 8'h0;
            tx_bit_clk[g] <= ~tx_bit_clk[g];
          end else begin
            rcnt[g] <= rcnt[g] + 8'h1;
          end
        end
      end
    end
  endgenerate

  // interrupt status: link errors low half, link up high half
  wire sts_rd = rd_go && paddr == `SWLC_IRQ_STS_OFS;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts <= {2*NLINK{1'b0}};
      irq     <= 1'b0;
    end else begin
      irq_sts <= (sts_rd ? irq_sts & ~prdata[2*NLINK-1:0] : irq_sts) | {ev_up, ev_err};
      irq     <= |(irq_sts & irq_mask);
    end
  end

  // read mux for the setup phase
  reg [31:0] next_rd;
  reg        next_err;
  always @* begin
    next_rd  = 32'h0;
    next_err = 1'b0;
    if (is_link(paddr)) begin
      next_rd[6:0]                               = ctrl[sel_n];
      next_rd[`SWLC_F_ERR]                       = err[sel_n];
      next_rd[`SWLC_F_STATE_HI:`SWLC_F_STATE_LO] = st_code(lst[sel_n]);
      next_rd[`SWLC_F_RUN]                       = (lst[sel_n] == ST_RUN);
    end else if (paddr == `SWLC_GLOBAL_OFS) begin
      next_rd[`SWLC_F_BASE_HI:`SWLC_F_BASE_LO] = base_tx_divider;
      next_rd[`SWLC_F_DEF_HI:`SWLC_F_DEF_LO]   = default_rate_divider;
      next_rd[`SWLC_F_PLL_HI:`SWLC_F_PLL_LO]   = pll_s;
    end else if (paddr == `SWLC_IRQ_STS_OFS) begin
      next_rd[2*NLINK-1:0] = irq_sts;
    end else if (paddr == `SWLC_IRQ_MSK_OFS) begin
      next_rd[2*NLINK-1:0] = irq_mask;
    end else begin
      next_err = 1'b1;
    end
  end

  // apb answer: ready, data and error raised in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? next_rd : 32'h0;
      pslverr <= psel & ~penable & next_err;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/swlc_link_ctrl_asserts.sv
// swlc_link_ctrl_asserts: port-level properties of the link control block
// assumes one pclk domain, presetn active low, bound below
`timescale 1ns/1ps
`default_nettype none
module swlc_link_ctrl_asserts #(parameter NLINK = 8) (
  // clock, reset and apb
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // link outputs
  input wire logic [NLINK-1:0] dout_oe,
  input wire logic [NLINK-1:0] sout_oe,
  input wire logic [NLINK-1:0] data_enable,
  input wire logic [NLINK-1:0] default_rate_active,
  input wire logic             irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer shape
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  AST_IDLE_RDATA: assert property (!pready |-> prdata == '0)
    else $error("read data not zero outside an access");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h28 |=> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  // strobe driver follows data driver one clock later so they never switch together
  AST_SOUT_LAG: assert property (sout_oe == $past(dout_oe))
    else $error("strobe enable not one clock behind data enable");
  // data never moves while the start-up divider is in use
  AST_RUN_NOT_DEFAULT: assert property ((data_enable & default_rate_active) == '0)
    else $error("data enabled while default rate active");
  // the connect phase is long, so a fresh driver enable never means data at once
  AST_CONN_WAIT: assert property ($rose(dout_oe[0]) |-> !data_enable[0] [*8])
    else $error("data enabled too soon after connect");
  AST_RESET_STATE: assert property ($rose(presetn) |-> data_enable == '0 && !irq)
    else $error("link not idle after reset");
  cover property ($rose(data_enable[0]));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule
bind swlc_link_ctrl swlc_link_ctrl_asserts #(.NLINK(NLINK)) chk (.pclk, .presetn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .dout_oe, .sout_oe, .data_enable,
  .default_rate_active, .irq);
`default_nettype wire

// ===== testbench/swlc_peer.sv
// swlc_peer: remote link end driving the peer status pins
// assumes the bench changes call, answer and hang just after a pclk edge
`timescale 1ns/1ps
`default_nettype none
module swlc_peer #(parameter int LAG = 3) (
  // bench controls and our driver enables
  input  wire logic      pclk,
  input  wire logic [7:0] dout_oe,
  input  wire logic [7:0] call,
  input  wire logic [7:0] answer,
  input  wire logic [7:0] hang,
  // pins into the port
  output var logic [7:0] peer_attempt = '0,
  output var logic [7:0] peer_lost = '0
);
  logic [7:0] seen [LAG];
  // answers LAG clocks after it first sees our drivers on, like a slow peer
  always @(posedge pclk) begin
    seen[0] <= dout_oe;
    for (int k = 1; k < LAG; k++) seen[k] <= seen[k-1];
    peer_attempt <= ~hang & (call | (answer & seen[LAG-1]));
    peer_lost <= hang;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_spacewire_link_control.sv
// tb_spacewire_link_control: register, start-up and rate checks
// assumes swlc_peer on the peer pins and the checker bound in the dut
`timescale 1ns/1ps
`default_nettype none
module tb_spacewire_link_control;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, er;
  logic [7:0]  paddr = '0, call = '0, answer = '0, hang = '0;
  logic [31:0] pwdata = '0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  wire  [7:0]  att, lost, doe, soe, den, bclk, dra;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, i;

  // feedback select held at 5
  swlc_link_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pll_feedback_select(3'h5),
    .peer_attempt(att), .peer_lost(lost), .link_fault(8'h00), .dout_oe(doe),
    .sout_oe(soe), .data_enable(den), .tx_bit_clk(bclk), .default_rate_active(dra), .irq);
  swlc_peer #(.LAG(3)) peer (.pclk, .dout_oe(doe), .call, .answer, .hang,
    .peer_attempt(att), .peer_lost(lost));

  // 100 ns clock
  always #50 pclk = ~pclk;
  // the sequence needs about 300 clocks
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; a spare edge first so psel is never set twice at once
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, rd, e);
  endtask
  task automatic wait_den(int n, logic v);
    i = 0;
    while (den[n] !== v && i < 200) begin
      @(posedge pclk);
      i++;
    end
    chk("data_enable", den[n], v);
  endtask
  // skip a possibly mixed half period and one whole one, then count the next
  task automatic half(int n, int e);
    logic b;
    int   c;
    c = 0;
    repeat (2) begin
      b = bclk[n];
      while (bclk[n] === b) @(posedge pclk);
    end
    b = bclk[n];
    while (bclk[n] === b) begin
      @(posedge pclk);
      c++;
    end
    chk("half period", c, e);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) rc("link ctrl", 8'(4 * k), 32'h00000001);
    rc("global", 8'h20, 32'h00050400);
    rc("mask", 8'h28, 32'h00000000);
    apb(1'b0, 8'h40, '0);
    chk("unmapped", {rd[30:0], er}, 32'h00000001);
    apb(1'b1, 8'h20, 32'h00000401);
    apb(1'b1, 8'h00, 32'h00000019);
    repeat (10) @(posedge pclk);
    chk("dout_oe quiet", doe[0], 1'b0);
    call[0] <= 1'b1;
    wait_den(0, 1'b1);
    chk("drivers", {doe[0], soe[0], dra[0]}, 3'h6);
    rc("link0 run", 8'h00, 32'h00000e19);
    half(0, 4);
    apb(1'b1, 8'h00, 32'h00000079);
    half(0, 16);
    half(2, 10);
    apb(1'b1, 8'h28, 32'h00000100);
    repeat (2) @(posedge pclk);
    chk("irq set", irq, 1'b1);
    rc("status", 8'h24, 32'h00000100);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 1'b0);
    hang[0] <= 1'b1;
    wait_den(0, 1'b0);
    repeat (3) @(posedge pclk);
    chk("drivers off", {doe[0], soe[0]}, 2'h0);
    rc("link0 err", 8'h00, 32'h00000179);
    rc("link0 err clr", 8'h00, 32'h00000079);
    call[1] <= 1'b1;
    wait_den(1, 1'b1);
    apb(1'b1, 8'h04, 32'h0000000f);
    wait_den(1, 1'b0);
    repeat (30) @(posedge pclk);
    chk("link1 off", {den[1], doe[1], soe[1]}, 3'h0);
    // peer answers only after start is set, so the start state is used
    apb(1'b1, 8'h08, 32'h00000002);
    answer[2] <= 1'b1;
    wait_den(2, 1'b1);
    rc("status late", 8'h24, 32'h00000601);
    finish_test();
  end
endmodule
`default_nettype wire
